// ==== rtl/dc_input_lock_and_alarm_control.sv ====
// standby lock, dc input switching and alarm handling with avalon register access
// Functional notes
// (R1) in analog remote only the standby pin decides the dc input state
// (R2) a register bit inverts the meaning of the standby pin
// (R3) an open standby pin reads as high
// (R4) normal level, pin high: entering analog remote switches the input on
// (R5) input off, effective level asserted: switch-on by panel or command accepted
// (R6) input off, effective level deasserted: input locked, switch-on ignored
// (R7) input on, effective level asserted: stays on, switchable both ways
// (R8) input on, level deasserts: switch off and lock; reasserting allows switch-on
// (R9) controller pulls remote select low to enter analog remote
// (R10) resistance pin tied low keeps resistance mode disabled
// (R11) reduced input range halves set and actual value resolution
// (R12) event action alarm switches off; signal or warning do not
// (R13) event action none is disabled, no reaction
// (R14) signal and warning both light the error led, not readable
// (R15) event alarm: led lit, input off, status readable
// (R16) device alarm: input off, led, alarm pin, readable status
// (R17) alarms stay latched until acknowledged
// (R18) manual: first press acknowledges, second press switches on
// (R19) digital remote: acknowledge command clears pending alarms
// (R20) overvoltage protect trips at threshold and switches off
// (R21) overcurrent protect trips at threshold up to 1.1 nominal
// (R22) overpower protect trips at threshold up to 1.1 nominal
// (R23) full range quantises values into 26214 steps
// (R24) standby pin synchronised and debounced before use
// (R25) pending alarm or lock beats any switch-on request
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`include "dcl_cfg.svh"
module dc_input_lock_and_alarm_control
    import dcl_pkg::*;
#(
    parameter int DEB_CYCLES = `DEB_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // avalon-mm slave
    input  wire dcl_pkg::avs_req_t avs_req,
    output logic            [31:0] avs_readdata,
    output logic                   avs_waitrequest,
    // analog interface pins
    input  wire logic              standby_pin_sink,
    input  wire logic              remote_select_n,
    input  wire logic              resistance_pin_sink,
    output logic                   alarm_pin,
    // front panel
    input  wire logic              panel_press,
    output logic                   error_led,
    // measurements, event conditions and set values
    input  wire dcl_pkg::meas_t    meas,
    input  wire logic        [4:0] event_cond,
    input  wire logic       [15:0] current_setpoint_in,
    input  wire logic       [15:0] voltage_setpoint_in,
    // control outputs
    output logic                   dc_on,
    output logic                   input_locked,
    output logic                   r_mode_enable,
    output logic            [15:0] current_setpoint_q,
    output logic            [15:0] voltage_setpoint_q,
    output logic            [15:0] volt_monitor,
    output logic            [15:0] curr_monitor
);
    import dcl_pkg::*;

    localparam int NE = `EVT_NUM;

    typedef struct packed {
        logic              inv;
        logic              half;
        logic              drem;
        logic [15:0]       ovp_thr;
        logic [15:0]       ocp_thr;
        logic [15:0]       opp_thr;
        logic [2*NE-1:0]   evt_act;
        logic              dc_on;
        logic              locked;
        prot_t             alm;
        logic              warn;
        logic              led;
        logic              alarm_pin;
        logic              rmode;
        logic              eff_q;
        logic              bus_done;
        logic [31:0]       rdata;
        logic [15:0]       vmon;
        logic [15:0]       imon;
    } st_t;

    st_t             st_r;
    st_t             st_nxt;
    logic            pin_level;
    logic            eff;
    logic            remote;
    logic            manual;
    logic            req;
    logic            acc;
    logic            wr_cmd;
    logic            ack;
    logic            pending;
    logic            panel_ack;
    logic            panel_tog;
    logic            sw_on;
    logic            sw_off;
    prot_t           set;
    logic [NE-1:0]   evt_alarm;
    logic [NE-1:0]   evt_warn;
    logic [1:0][15:0] sp_raw;
    logic [1:0][15:0] sp_q;

    function automatic action_t act_of(input logic [2*NE-1:0] v, input int i);
        act_of = action_t'(v[2*i +: 2]);
    endfunction : act_of

    function automatic logic [15:0] clamp_thr(input logic [31:0] d);
        clamp_thr = (d[15:0] > `THR_MAX || d[31:16] != 16'h0) ? `THR_MAX : d[15:0];
    endfunction : clamp_thr

    function automatic logic [31:0] reg_read(input logic [7:0] a, input st_t s, input logic rem);
        logic [31:0] r;
        r = '0;
        case (a)
            `REG_CTRL:
            begin
                r[`CTRL_INV] = s.inv;
                r[`CTRL_HALF] = s.half;
                r[`CTRL_DREM] = s.drem;
            end
            `REG_STATUS:
            begin
                r[`ST_DC] = s.dc_on;
                r[`ST_LOCK] = s.locked;
                r[`ST_REMOTE] = rem;
                r[`ST_RMODE] = s.rmode;
                r[`ST_OVP] = s.alm.overvoltage_protect;
                r[`ST_OCP] = s.alm.overcurrent_protect;
                r[`ST_OPP] = s.alm.overpower_protect;
                r[`ST_EVT] = s.alm.evt;
            end
            `REG_EVT:  r[2*NE-1:0] = s.evt_act;
            `REG_OVP:  r[15:0] = s.ovp_thr;
            `REG_OCP:  r[15:0] = s.ocp_thr;
            `REG_OPP:  r[15:0] = s.opp_thr;
            `REG_VMON: r[15:0] = s.vmon;
            `REG_IMON: r[15:0] = s.imon;
            default:   r = '0;
        endcase
        return r;
    endfunction : reg_read

    // open pin: sink off means high
    standby_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (~standby_pin_sink), // R3
        .level_out (pin_level)          // R24
    );

    assign sp_raw = {voltage_setpoint_in, current_setpoint_in};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_sp
            quant_steps u_q (
                .clk   (clk),
                .rst_n (rst_n),
                .raw   (sp_raw[g]),
                .half  (st_r.half), // R11
                .steps (sp_q[g])    // R23
            );
        end
        for (g = 0; g < NE; g++)
        begin : g_evt
            // events only act while the input is on
            assign evt_alarm[g] = st_r.dc_on && event_cond[g] && act_of(st_r.evt_act, g) == ACT_ALARM; // R12
            assign evt_warn[g] = st_r.dc_on && event_cond[g] &&
                                 (act_of(st_r.evt_act, g) == ACT_SIGNAL ||
                                  act_of(st_r.evt_act, g) == ACT_WARNING); // R14
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;
        eff = pin_level ^ st_r.inv; // R2
        remote = ~remote_select_n; // R9
        manual = ~remote & ~st_r.drem;
        req = avs_req.read | avs_req.write;
        acc = req & st_r.bus_done;
        wr_cmd = acc & avs_req.write && avs_req.address == `REG_CMD;
        pending = (st_r.alm != '0) | st_r.warn;
        panel_ack = manual & panel_press & pending; // R18
        panel_tog = manual & panel_press & ~pending; // R18
        // analog remote: rising edge of the effective level acknowledges
        ack = panel_ack | (wr_cmd & avs_req.writedata[`CMD_ACK]) | (remote & eff & ~st_r.eff_q); // R19
        sw_on = (panel_tog & ~st_r.dc_on) | (wr_cmd & st_r.drem & ~remote & avs_req.writedata[`CMD_ON]);
        sw_off = (panel_tog & st_r.dc_on) | (wr_cmd & st_r.drem & ~remote & avs_req.writedata[`CMD_OFF]);

        // one wait cycle, read data loaded on the first
        st_nxt.bus_done = req & ~st_r.bus_done;
        if (req & ~st_r.bus_done)
            st_nxt.rdata = reg_read(avs_req.address, st_r, remote);
        if (acc & avs_req.write)
        begin
            case (avs_req.address)
                `REG_CTRL:
                begin
                    st_nxt.inv = avs_req.writedata[`CTRL_INV]; // R2
                    st_nxt.half = avs_req.writedata[`CTRL_HALF];
                    st_nxt.drem = avs_req.writedata[`CTRL_DREM];
                end
                `REG_EVT: st_nxt.evt_act = avs_req.writedata[2*NE-1:0]; // R13
                `REG_OVP: st_nxt.ovp_thr = clamp_thr(avs_req.writedata);
                `REG_OCP: st_nxt.ocp_thr = clamp_thr(avs_req.writedata); // R21
                `REG_OPP: st_nxt.opp_thr = clamp_thr(avs_req.writedata); // R22
                default: ;
            endcase
        end

        // protection thresholds, set wins over acknowledge
        set.overvoltage_protect = meas.volt >= st_r.ovp_thr; // R20
        set.overcurrent_protect = meas.curr >= st_r.ocp_thr; // R21
        set.overpower_protect = meas.power >= st_r.opp_thr; // R22
        set.evt = |evt_alarm; // R15
        st_nxt.alm = set | (st_r.alm & ~{4{ack}}); // R17
        st_nxt.warn = (|evt_warn) | (st_r.warn & ~ack); // R14
        st_nxt.led = (st_nxt.alm != '0) | st_nxt.warn; // R15
        st_nxt.alarm_pin = st_nxt.alm.overvoltage_protect | st_nxt.alm.overcurrent_protect | st_nxt.alm.overpower_protect; // R16

        if (remote)
            st_nxt.dc_on = eff; // R1 R4
        else if (~eff)
            st_nxt.dc_on = 1'b0; // R6 R8
        else if (sw_on)
            st_nxt.dc_on = 1'b1; // R5
        else if (sw_off)
            st_nxt.dc_on = 1'b0; // R7
        if ((st_r.alm != '0) | (set != '0))
            st_nxt.dc_on = 1'b0; // R16 R25
        st_nxt.locked = ~remote & ~eff; // R6
        st_nxt.eff_q = eff;
        st_nxt.rmode = ~resistance_pin_sink; // R10
        st_nxt.vmon = st_r.half ? {meas.volt[15:1], 1'b0} : meas.volt; // R11
        st_nxt.imon = st_r.half ? {meas.curr[15:1], 1'b0} : meas.curr;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.eff_q <= 1'b1;
            st_r.ovp_thr <= `THR_MAX;
            st_r.ocp_thr <= `THR_MAX;
            st_r.opp_thr <= `THR_MAX;
            st_r.evt_act <= `EVT_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign avs_waitrequest = req & ~st_r.bus_done;
    assign avs_readdata = st_r.rdata;
    assign dc_on = st_r.dc_on;
    assign input_locked = st_r.locked;
    assign error_led = st_r.led;
    assign alarm_pin = st_r.alarm_pin;
    assign r_mode_enable = st_r.rmode;
    assign voltage_setpoint_q = sp_q[1];
    assign current_setpoint_q = sp_q[0];
    assign volt_monitor = st_r.vmon;
    assign curr_monitor = st_r.imon;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_remote_follows_pin: assert property (remote && eff && st_r.alm == '0 && set == '0 |=> dc_on) // R1
        else $error("remote with asserted pin did not switch on");
    a_lock_blocks_on: assert property (!remote && !eff |=> !dc_on && input_locked) // R6
        else $error("locked input switched on");
    a_level_fall_off: assert property (!remote && dc_on && !eff |=> !dc_on) // R8
        else $error("deasserted pin did not switch off");
    a_panel_switch_on: assert property (panel_tog && !dc_on && eff && !remote && set == '0 |=> dc_on) // R5
        else $error("unlocked panel switch-on refused");
    a_alarm_forces_off: assert property (st_r.alm != '0 |=> !dc_on) // R25
        else $error("input on while alarm pending");
    a_ovp_trip: assert property (meas.volt >= st_r.ovp_thr |=> st_r.alm.overvoltage_protect && alarm_pin ##1 !dc_on) // R20
        else $error("overvoltage did not trip");
    a_alarm_sticky: assert property (st_r.alm.overcurrent_protect && !ack |=> st_r.alm.overcurrent_protect) // R17
        else $error("alarm cleared without acknowledge");
    a_ack_clears: assert property (ack && set == '0 && event_cond == '0 |=> st_r.alm == '0 && !error_led) // R19
        else $error("acknowledge left alarms");
    a_led_tracks: assert property (error_led == ((st_r.alm != '0) || st_r.warn)) // R15
        else $error("error led disagrees with alarms");
    a_none_silent: assert property (st_r.evt_act == '0 && !st_r.warn && st_r.alm.evt == 1'b0
                                    |=> !st_r.warn && !st_r.alm.evt) // R13
        else $error("disabled event reacted");
    a_rmode_off: assert property (resistance_pin_sink |=> !r_mode_enable) // R10
        else $error("resistance mode on with pin low");
    a_bus_one_wait: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    c_remote_on: cover property (!remote ##1 remote && eff ##1 dc_on);
    c_lock_toggle: cover property (dc_on && !remote ##1 !eff ##1 eff ##[1:8] dc_on);
    c_panel_ack: cover property (panel_ack ##1 st_r.alm == '0);
    c_event_warn: cover property ($rose(st_r.warn));
endmodule : dc_input_lock_and_alarm_control

// ==== rtl/dcl_cfg.svh ====
// offsets, field positions, reset values and timing counts of the dc input control
`ifndef DCL_CFG_SVH
`define DCL_CFG_SVH
`define CLK_MHZ      250
`define DEB_TIME_NS  100000
`define DEB_CYCLES   (`DEB_TIME_NS * `CLK_MHZ / 1000)
`define STEPS_FULL   32'd26214
`define THR_MAX      16'd28835
`define EVT_NUM      5
`define REG_CTRL     8'h00
`define REG_CMD      8'h04
`define REG_STATUS   8'h08
`define REG_EVT      8'h0c
`define REG_OVP      8'h10
`define REG_OCP      8'h14
`define REG_OPP      8'h18
`define REG_VMON     8'h1c
`define REG_IMON     8'h20
`define CTRL_INV     0
`define CTRL_HALF    1
`define CTRL_DREM    2
`define CMD_ON       0
`define CMD_OFF      1
`define CMD_ACK      2
`define ST_DC        0
`define ST_LOCK      1
`define ST_REMOTE    2
`define ST_RMODE     3
`define ST_OVP       4
`define ST_OCP       5
`define ST_OPP       6
`define ST_EVT       7
`define CTRL_RST     3'h0
`define EVT_RST      10'h000
`endif

// ==== rtl/dcl_pkg.sv ====
// shared types of the dc input control
package dcl_pkg;
    typedef enum logic [1:0] {ACT_NONE, ACT_SIGNAL, ACT_WARNING, ACT_ALARM} action_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } avs_req_t;

    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
        logic [15:0] power;
    } meas_t;

    typedef struct packed {
        logic overvoltage_protect;
        logic overcurrent_protect;
        logic overpower_protect;
        logic evt;
    } prot_t;
endpackage : dcl_pkg

// ==== rtl/quant_steps.sv ====
// converts a 16-bit converter code into set or actual value steps
module quant_steps (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // code in, steps out
    input  wire logic [15:0] raw,
    input  wire logic        half,
    output logic      [15:0] steps
);
    `include "dcl_cfg.svh"

    typedef struct packed {
        logic [15:0] steps;
    } q_t;

    q_t          st_r;
    q_t          st_nxt;
    logic [31:0] prod;

    always_comb
    begin
        prod = 32'(raw) * `STEPS_FULL;
        st_nxt.steps = prod[31:16];
        if (half)
            st_nxt.steps[0] = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign steps = st_r.steps;
endmodule : quant_steps

// ==== rtl/standby_debounce.sv ====
// synchroniser and debouncer for the standby pin
`include "dcl_cfg.svh"
module standby_debounce #(
    parameter int DEB_CYCLES = `DEB_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin level and filtered level
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        level;
        logic [31:0] cnt;
    } deb_t;

    deb_t st_r;
    deb_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        if (st_r.s2 == st_r.level)
            st_nxt.cnt = '0;
        else if (st_r.cnt >= 32'(DEB_CYCLES - 1))
        begin
            st_nxt.level = st_r.s2;
            st_nxt.cnt = '0;
        end
        else
            st_nxt.cnt = st_r.cnt + 32'd1;
    end

    // open pin idles high
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_r <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: 32'h0};
        else
            st_r <= st_nxt;
    end

    assign level_out = st_r.level;
endmodule : standby_debounce

// ==== testbench/analog_ctrl_model.sv ====
// behavioural model of the external controller at the analog pins
module analog_ctrl_model (
    // clock
    input  wire logic clk,
    // wanted contact states from the bench
    input  wire logic want_remote,
    input  wire logic want_sb_low,
    input  wire logic want_r_off,
    // contacts at the analog pins
    output logic      standby_pin_sink,
    output logic      remote_select_n,
    output logic      resistance_pin_sink
);
    timeunit 1ns;
    timeprecision 1ps;
    // contacts open unless closed on purpose
    always @(posedge clk)
    begin
        standby_pin_sink    <= want_sb_low;
        remote_select_n     <= !want_remote;
        resistance_pin_sink <= want_r_off;
    end
endmodule : analog_ctrl_model

// ==== testbench/dc_input_lock_and_alarm_control_tb.sv ====
// self-checking bench of the dc input lock and alarm control
`include "dcl_cfg.svh"
module dc_input_lock_and_alarm_control_tb;
    import dcl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEB = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    avs_req_t    req = '0;
    meas_t       meas = '0;
    logic [4:0]  event_cond = '0;
    logic [15:0] cur_in = '0;
    logic [15:0] volt_in = '0;
    logic        press = 1'b0;
    logic        want_remote = 1'b0;
    logic        sb_low = 1'b0;
    logic        r_off = 1'b0;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        wait_req;
    logic        sb_sink;
    logic        rsel_n;
    logic        r_sink;
    logic        alarm_pin;
    logic        led;
    logic        dc_on;
    logic        locked;
    logic        r_en;
    logic [15:0] cur_q;
    logic [15:0] volt_q;
    logic [15:0] vmon;
    logic [15:0] imon;
    int          err_count = 0;
    int          samples_checked = 0;
    logic [3:0]  ev_exp [4] = '{4'b1000, 4'b1010, 4'b1010, 4'b0010};

    always #2 clk = ~clk;

    analog_ctrl_model partner (.clk(clk), .want_remote(want_remote), .want_sb_low(sb_low), .want_r_off(r_off),
        .standby_pin_sink(sb_sink), .remote_select_n(rsel_n), .resistance_pin_sink(r_sink));

    dc_input_lock_and_alarm_control #(.DEB_CYCLES(DEB)) dut (.clk(clk), .rst_n(rst_n), .avs_req(req),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .standby_pin_sink(sb_sink), .remote_select_n(rsel_n),
        .resistance_pin_sink(r_sink), .alarm_pin(alarm_pin), .panel_press(press), .error_led(led), .meas(meas),
        .event_cond(event_cond), .current_setpoint_in(cur_in), .voltage_setpoint_in(volt_in), .dc_on(dc_on),
        .input_locked(locked), .r_mode_enable(r_en), .current_setpoint_q(cur_q), .voltage_setpoint_q(volt_q),
        .volt_monitor(vmon), .curr_monitor(imon));

    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        @(posedge clk);
        while (wait_req !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        // taken at the edge where waitrequest is low
        q = rdata;
        req <= '0;
        if (n == 20)
        begin
            err_count++;
            stop_test();
        end
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q & mask, exp);
    endtask : rd

    // {dc_on, input_locked, error_led, alarm_pin} after n cycles
    task automatic look(input int n, input logic [3:0] exp);
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk({28'h0, dc_on, locked, led, alarm_pin}, {28'h0, exp});
    endtask : look

    task automatic push();
        @(posedge clk);
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
    endtask : push

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`REG_CTRL, 32'hffffffff, 32'h0);
        rd(`REG_OVP, 32'hffffffff, 32'h70a3);
        rd(`REG_OCP, 32'hffffffff, 32'h70a3);
        rd(`REG_OPP, 32'hffffffff, 32'h70a3);
        rd(`REG_EVT, 32'hffffffff, 32'h0);
        rd(8'h40, 32'hffffffff, 32'h0);
        look(DEB + 4, 4'b0000);
        chk({31'h0, r_en}, 32'h1);
        @(posedge clk) r_off <= 1'b1;
        look(4, 4'b0000);
        chk({31'h0, r_en}, 32'h0);
        rd(`REG_STATUS, 32'h8, 32'h0);
        @(posedge clk) r_off <= 1'b0;
        // manual control with the standby pin as lock
        push();
        look(2, 4'b1000);
        push();
        look(2, 4'b0000);
        push();
        look(2, 4'b1000);
        @(posedge clk) sb_low <= 1'b1;
        @(posedge clk) sb_low <= 1'b0;
        look(DEB + 6, 4'b1000);
        @(posedge clk) sb_low <= 1'b1;
        look(DEB + 6, 4'b0100);
        push();
        look(2, 4'b0100);
        bus(1'b1, `REG_CMD, 32'h1);
        look(2, 4'b0100);
        bus(1'b1, `REG_CTRL, 32'h1);
        look(2, 4'b0000);
        push();
        look(2, 4'b1000);
        @(posedge clk) sb_low <= 1'b0;
        look(DEB + 6, 4'b0100);
        bus(1'b1, `REG_CTRL, 32'h0);
        look(2, 4'b0000);
        // analog remote: only the pin decides
        @(posedge clk) want_remote <= 1'b1;
        look(4, 4'b1000);
        rd(`REG_STATUS, 32'h7, 32'h5);
        push();
        look(2, 4'b1000);
        bus(1'b1, `REG_CMD, 32'h2);
        look(2, 4'b1000);
        @(posedge clk) sb_low <= 1'b1;
        look(DEB + 6, 4'b0000);
        @(posedge clk) want_remote <= 1'b0;
        look(4, 4'b0100);
        @(posedge clk) sb_low <= 1'b0;
        look(DEB + 6, 4'b0000);
        // protections, acknowledged from the panel
        for (int i = 0; i < 3; i++)
        begin
            push();
            look(2, 4'b1000);
            bus(1'b1, 8'(`REG_OVP + 4 * i), 32'h100);
            @(posedge clk) meas <= {(i == 0) ? 16'h100 : 16'h0, (i == 1) ? 16'h100 : 16'h0, (i == 2) ? 16'h100 : 16'h0};
            look(3, 4'b0011);
            rd(`REG_STATUS, 32'hf0, 32'h10 << i);
            @(posedge clk) meas <= '0;
            look(3, 4'b0011);
            push();
            look(2, 4'b0000);
        end
        // digital remote with command acknowledge
        bus(1'b1, `REG_CTRL, 32'h4);
        bus(1'b1, `REG_CMD, 32'h1);
        look(2, 4'b1000);
        @(posedge clk) meas.volt <= 16'h100;
        look(3, 4'b0011);
        @(posedge clk) meas.volt <= 16'h0;
        bus(1'b1, `REG_CMD, 32'h1);
        look(2, 4'b0011);
        bus(1'b1, `REG_CMD, 32'h4);
        look(2, 4'b0000);
        bus(1'b1, `REG_CMD, 32'h1);
        look(2, 4'b1000);
        // event actions none, signal, warning, alarm
        bus(1'b1, `REG_EVT, 32'he4);
        rd(`REG_EVT, 32'hffffffff, 32'he4);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk) event_cond <= 5'(1 << i);
            look(3, ev_exp[i]);
            rd(`REG_STATUS, 32'h80, (i == 3) ? 32'h80 : 32'h0);
            @(posedge clk) event_cond <= '0;
            bus(1'b1, `REG_CMD, 32'h4);
            bus(1'b1, `REG_CMD, 32'h1);
            look(2, 4'b1000);
        end
        // set and actual value quantisation
        @(posedge clk);
        cur_in <= 16'hffff;
        volt_in <= 16'h8000;
        meas <= '{volt: 16'h0055, curr: 16'h0033, power: 16'h0};
        look(4, 4'b1000);
        chk({cur_q, volt_q}, 32'h6665_3333);
        chk({vmon, imon}, 32'h0055_0033);
        bus(1'b1, `REG_CTRL, 32'h6);
        look(4, 4'b1000);
        chk({cur_q, volt_q}, 32'h6664_3332);
        chk({vmon, imon}, 32'h0054_0032);
        bus(1'b1, `REG_OCP, 32'hffff);
        rd(`REG_OCP, 32'hffffffff, 32'h70a3);
        stop_test();
    end
endmodule : dc_input_lock_and_alarm_control_tb
